// *** can_error_counters.sv ***
// Transmit and receive error counters with fault confinement updates.
`timescale 1ns/10ps
module can_error_counters (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Protocol engine events
  input  wire logic       txErrorEvent,
  input  wire logic       txSuccessEvent,
  input  wire logic       rxErrorEvent,
  input  wire logic       rxSevereErrorEvent,
  input  wire logic       rxSuccessEvent,
  input  wire logic       busOffRecover,
  // Counter state
  output logic [7:0]      txErrCount,
  output logic [7:0]      rxErrCount,
  output logic            busOff
);

  wire txOverflow = txErrCount > (8'hff - can_regs_pkg::ERR_STEP_BIG);
  wire [7:0] rxStep = rxSevereErrorEvent ? can_regs_pkg::ERR_STEP_BIG
                                         : can_regs_pkg::ERR_STEP_ONE;
  wire rxSat = rxErrCount > (8'hff - rxStep);

  always_ff @(posedge mclk) begin
    if (reset || busOffRecover) begin
      txErrCount <= can_regs_pkg::ERR_COUNT_RST; // RQ9
      busOff     <= 1'b0;
    end else if (txErrorEvent) begin
      txErrCount <= txOverflow ? 8'hff : txErrCount + can_regs_pkg::ERR_STEP_BIG; // RQ16
      busOff     <= busOff | txOverflow; // RQ16
    end else if (txSuccessEvent && txErrCount != 8'h00) begin
      txErrCount <= txErrCount - can_regs_pkg::ERR_STEP_ONE; // RQ16
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || busOffRecover) begin
      rxErrCount <= can_regs_pkg::ERR_COUNT_RST; // RQ10
    end else if (rxErrorEvent || rxSevereErrorEvent) begin
      rxErrCount <= rxSat ? 8'hff : rxErrCount + rxStep; // RQ16
    end else if (rxSuccessEvent) begin
      if (rxErrCount >= can_regs_pkg::PASSIVE_LIMIT) begin
        rxErrCount <= can_regs_pkg::REC_REENTRY; // RQ16
      end else if (rxErrCount != 8'h00) begin
        rxErrCount <= rxErrCount - can_regs_pkg::ERR_STEP_ONE; // RQ16
      end
    end
  end

endmodule : can_error_counters

// *** can_event_model.sv ***
// Far side model: bus peers and the engine raising events after a chosen delay.
`timescale 1ns/10ps
module can_event_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Request
  input  wire logic        evStart,
  input  wire logic [3:0]  evCode,
  input  wire logic [3:0]  evDelay,
  // Event pulses
  output logic      [11:0] evPulse,
  output logic             evBusy
);
  logic [3:0] cntQ;
  logic [3:0] codeQ;

  always_ff @(posedge mclk) begin
    evPulse <= 12'h000;
    if (reset) begin
      evBusy <= 1'b0;
    end else if (evStart) begin
      evBusy <= 1'b1;
      cntQ <= evDelay;
      codeQ <= evCode;
    end else if (evBusy && cntQ == 4'h0) begin
      evPulse <= 12'h001 << codeQ;
      evBusy <= 1'b0;
    end else if (evBusy) begin
      cntQ <= cntQ - 4'h1;
    end
  end
endmodule : can_event_model

// *** can_irq_timing_regs.sv ***
// CAN interrupt enable, error count and bit timing registers behind AXI4-Lite.
//
// Operation
// RQ1 - Bits 15..8 and bit 4 of the enable register and bits 15..8 of the timing register read 0.
// RQ2 - Enable bit 7 lets an invalid-message flag interrupt and resets to 0.
// RQ3 - Enable bit 6 lets a bus wake-up flag interrupt and resets to 0.
// RQ4 - Enable bit 5 lets the combined error flag interrupt and resets to 0.
// RQ5 - Enable bit 3 lets the receive FIFO almost-full flag interrupt and resets to 0.
// RQ6 - Enable bit 2 lets a receive overflow flag interrupt and resets to 0.
// RQ7 - Enable bit 1 lets a receive buffer full flag interrupt and resets to 0.
// RQ8 - Enable bit 0 lets a transmit buffer flag interrupt and resets to 0.
// RQ9 - The transmit error count reads in bits 15..8 of the count register, 0 after reset.
// RQ10 - The receive error count reads in bits 7..0 of the count register, 0 after reset.
// RQ11 - Timing bits 7..6 pick a jump width of one to four quanta and reset to 0.
// RQ12 - Timing bits 5..0 set a quantum of 2 x (field + 1) module clocks.
// RQ13 - Each enable bit gates the flag at the same bit position.
// RQ14 - The combined error flag collects the error state bits 13..8 of the flag register.
// RQ15 - The interrupt output is high while any flag and its enable are both set.
// RQ16 - The error counters follow the CAN fault confinement rules from engine events.
`timescale 1ns/10ps
module can_irq_timing_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Interrupt source events
  input  wire logic        badMsgEvent,
  input  wire logic        wakeEvent,
  input  wire logic        fifoFullEvent,
  input  wire logic        rxOverflowEvent,
  input  wire logic        rxBufferEvent,
  input  wire logic        txBufferEvent,
  // Fault confinement events
  input  wire logic        txErrorEvent,
  input  wire logic        txSuccessEvent,
  input  wire logic        rxErrorEvent,
  input  wire logic        rxSevereErrorEvent,
  input  wire logic        rxSuccessEvent,
  input  wire logic        busOffRecover,
  // Bit timing outputs
  output logic             tqTick,
  output logic [2:0]       syncJumpQuanta,
  // Interrupt
  output logic             irq
);

  // --------------------
  // Address decode
  // --------------------
  function automatic can_regs_pkg::reg_sel_t decodeAddr(input logic [7:0] addr);
    can_regs_pkg::reg_sel_t sel;
    sel = can_regs_pkg::SEL_NONE;
    unique case (addr)
      can_regs_pkg::OFF_IRQ_ENABLE:   sel = can_regs_pkg::SEL_ENABLE;
      can_regs_pkg::OFF_ERROR_COUNTS: sel = can_regs_pkg::SEL_COUNTS;
      can_regs_pkg::OFF_BIT_TIMING:   sel = can_regs_pkg::SEL_TIMING;
      can_regs_pkg::OFF_IRQ_FLAGS:    sel = can_regs_pkg::SEL_FLAGS;
      default:                        sel = can_regs_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decodeAddr

  // --------------------
  // Register state
  // --------------------
  logic [7:0]  irqEnable_q;
  logic [7:0]  bitTiming_q;
  logic [7:0]  irqFlags_q;
  logic [5:0]  errState_q;
  logic [7:0]  awaddr_q;
  logic [7:0]  wdata_q;
  logic [0:0]  wstrb_q;
  logic [7:0]  txErrCount;
  logic [7:0]  rxErrCount;
  logic        busOff;

  // --------------------
  // Write channel
  // --------------------
  // Address and data are each taken once and held until the response is
  // accepted, so either may arrive first and only one write is open.
  wire awTake  = awvalid && awready;
  wire wTake   = wvalid && wready;
  wire wrFire  = !awready && !wready && !bvalid;
  wire bDone   = bvalid && bready;

  wire can_regs_pkg::reg_sel_t wrSel = decodeAddr(awaddr_q);
  wire wrMapped   = (wrSel != can_regs_pkg::SEL_NONE);
  wire wrEnable   = wrFire && (wrSel == can_regs_pkg::SEL_ENABLE) && wstrb_q[0];
  wire wrTiming   = wrFire && (wrSel == can_regs_pkg::SEL_TIMING) && wstrb_q[0];
  wire wrFlags    = wrFire && (wrSel == can_regs_pkg::SEL_FLAGS) && wstrb_q[0];

  always_ff @(posedge mclk) begin
    if (reset) begin
      awready  <= 1'b1;
      awaddr_q <= 8'h00;
    end else if (awTake) begin
      awready  <= 1'b0;
      awaddr_q <= awaddr;
    end else if (bDone) begin
      awready  <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wready  <= 1'b1;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else if (wTake) begin
      wready  <= 1'b0;
      wdata_q <= wdata[7:0];
      wstrb_q <= wstrb[0];
    end else if (bDone) begin
      wready  <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp  <= can_regs_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp  <= wrMapped ? can_regs_pkg::RESP_OKAY : can_regs_pkg::RESP_DECERR;
    end else if (bDone) begin
      bvalid <= 1'b0;
    end
  end

  // --------------------
  // Interrupt enable and bit timing registers
  // --------------------
  // Upper byte lane carries no storage in either register, so its strobe
  // is ignored and the bits always read back as zero.
  wire [7:0] enableWrite = wdata_q[7:0] & can_regs_pkg::IRQ_BITS_MASK; // RQ1

  always_ff @(posedge mclk) begin
    if (reset) begin
      irqEnable_q <= can_regs_pkg::IRQ_ENABLE_RST; // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
    end else if (wrEnable) begin
      irqEnable_q <= enableWrite; // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bitTiming_q <= can_regs_pkg::BIT_TIMING_RST; // RQ11
    end else if (wrTiming) begin
      bitTiming_q <= wdata_q[7:0]; // RQ11
    end
  end

  wire [1:0] syncJumpWidth = bitTiming_q[can_regs_pkg::SJW_LSB +: 2];
  wire [can_regs_pkg::PRESCALER_W-1:0] quantumPrescaler =
    bitTiming_q[can_regs_pkg::PRESCALER_W-1:0];

  always_ff @(posedge mclk) begin
    if (reset) begin
      syncJumpQuanta <= 3'h1;
    end else begin
      syncJumpQuanta <= {1'b0, syncJumpWidth} + 3'h1; // RQ11
    end
  end

  can_quantum_divider quantumDivider (
    .mclk             (mclk),
    .reset            (reset),
    .quantumPrescaler (quantumPrescaler),
    .tqTick           (tqTick)
  );

  // --------------------
  // Error counters and error state
  // --------------------
  can_error_counters errorCounters (
    .mclk               (mclk),
    .reset              (reset),
    .txErrorEvent       (txErrorEvent),
    .txSuccessEvent     (txSuccessEvent),
    .rxErrorEvent       (rxErrorEvent),
    .rxSevereErrorEvent (rxSevereErrorEvent),
    .rxSuccessEvent     (rxSuccessEvent),
    .busOffRecover      (busOffRecover),
    .txErrCount         (txErrCount),
    .rxErrCount         (rxErrCount),
    .busOff             (busOff)
  );

  wire txWarn    = txErrCount >= can_regs_pkg::WARN_LIMIT;
  wire rxWarn    = rxErrCount >= can_regs_pkg::WARN_LIMIT;
  wire txPassive = txErrCount >= can_regs_pkg::PASSIVE_LIMIT;
  wire rxPassive = rxErrCount >= can_regs_pkg::PASSIVE_LIMIT;
  // Order: bus off, tx passive, rx passive, tx warn, rx warn, any warn.
  wire [5:0] errState = {busOff, txPassive, rxPassive, txWarn, rxWarn, txWarn | rxWarn};
  wire       errRise  = |(errState & ~errState_q); // RQ14

  always_ff @(posedge mclk) begin
    if (reset) begin
      errState_q <= 6'h00;
    end else begin
      errState_q <= errState; // RQ14
    end
  end

  // --------------------
  // Interrupt flags
  // --------------------
  // A source pulse in the clearing cycle survives: set is applied after clear.
  wire [7:0] flagSet;
  assign flagSet[can_regs_pkg::BIT_BAD_MSG]   = badMsgEvent;
  assign flagSet[can_regs_pkg::BIT_WAKE]      = wakeEvent;
  assign flagSet[can_regs_pkg::BIT_ERR]       = errRise; // RQ14
  assign flagSet[4]                           = 1'b0;
  assign flagSet[can_regs_pkg::BIT_FIFO_FULL] = fifoFullEvent;
  assign flagSet[can_regs_pkg::BIT_RX_OVF]    = rxOverflowEvent;
  assign flagSet[can_regs_pkg::BIT_RX_BUF]    = rxBufferEvent;
  assign flagSet[can_regs_pkg::BIT_TX_BUF]    = txBufferEvent;

  wire [7:0] flagClear = wrFlags ? (wdata_q[7:0] & can_regs_pkg::IRQ_BITS_MASK) : 8'h00;
  wire [7:0] irqFlags_d = (irqFlags_q & ~flagClear) | flagSet;
  wire [7:0] pending    = irqFlags_q & irqEnable_q; // RQ13

  always_ff @(posedge mclk) begin
    if (reset) begin
      irqFlags_q <= can_regs_pkg::IRQ_FLAGS_RST;
      irq        <= 1'b0;
    end else begin
      irqFlags_q <= irqFlags_d;
      irq        <= |pending; // RQ15
    end
  end

  // --------------------
  // Read channel
  // --------------------
  wire arTake = arvalid && arready;
  wire rDone  = rvalid && rready;
  wire can_regs_pkg::reg_sel_t rdSel = decodeAddr(araddr);

  wire [15:0] enableWord = {8'h00, irqEnable_q & can_regs_pkg::IRQ_BITS_MASK}; // RQ1
  wire [15:0] countWord  = {txErrCount, rxErrCount}; // RQ9 RQ10
  wire [15:0] timingWord = {8'h00, bitTiming_q}; // RQ1
  wire [15:0] flagWord   = {2'h0, errState_q, irqFlags_q}; // RQ14

  wire [15:0] rdWord =
    (rdSel == can_regs_pkg::SEL_ENABLE) ? enableWord :
    (rdSel == can_regs_pkg::SEL_COUNTS) ? countWord  :
    (rdSel == can_regs_pkg::SEL_TIMING) ? timingWord :
    (rdSel == can_regs_pkg::SEL_FLAGS)  ? flagWord   : 16'h0000;
  wire rdMapped = (rdSel != can_regs_pkg::SEL_NONE);

  always_ff @(posedge mclk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= can_regs_pkg::RESP_OKAY;
    end else if (arTake) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {16'h0000, rdWord};
      rresp   <= rdMapped ? can_regs_pkg::RESP_OKAY : can_regs_pkg::RESP_DECERR;
    end else if (rDone) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

endmodule : can_irq_timing_regs

// *** can_irq_timing_regs_chk.sv ***
// Concurrent checks on the ports of the CAN register block.
`timescale 1ns/10ps
module can_irq_timing_regs_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Register bus
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Interrupt sources
  input wire logic        badMsgEvent,
  input wire logic        wakeEvent,
  input wire logic        fifoFullEvent,
  input wire logic        rxOverflowEvent,
  input wire logic        rxBufferEvent,
  input wire logic        txBufferEvent,
  // Outputs
  input wire logic        tqTick,
  input wire logic [2:0]  syncJumpQuanta,
  input wire logic        irq
);
  // --------------------
  // Shadow of written registers
  // --------------------
  // A prescaler change makes one tick interval irregular, so that interval is skipped.
  logic [7:0] awAddrQ, rdAddrQ, wDataQ, enQ, tmQ, gapQ;
  logic       awGotQ, wGotQ, wStrbQ, tickSeenQ, chgQ;
  wire        fire = awGotQ && wGotQ && !bvalid;
  wire  [7:0] evVec = {badMsgEvent, wakeEvent, 2'b00, fifoFullEvent, rxOverflowEvent,
                       rxBufferEvent, txBufferEvent};
  wire  [7:0] period = {1'b0, tmQ[5:0], 1'b0} + 8'h02;

  always_ff @(posedge mclk) begin
    if (reset) begin
      awGotQ <= 1'b0;
      wGotQ <= 1'b0;
      enQ <= 8'h00;
      tmQ <= 8'h00;
      tickSeenQ <= 1'b0;
      chgQ <= 1'b0;
      gapQ <= 8'h00;
    end else begin
      if (awvalid && awready) awAddrQ <= awaddr;
      if (wvalid && wready) wDataQ <= wdata[7:0];
      if (wvalid && wready) wStrbQ <= wstrb[0];
      awGotQ <= fire ? 1'b0 : (awGotQ || (awvalid && awready));
      wGotQ <= fire ? 1'b0 : (wGotQ || (wvalid && wready));
      if (fire && wStrbQ && awAddrQ == 8'h00) enQ <= wDataQ & 8'hef;
      if (fire && wStrbQ && awAddrQ == 8'h08) tmQ <= wDataQ;
      chgQ <= (fire && awAddrQ == 8'h08) || (chgQ && !tqTick);
      if (tqTick) tickSeenQ <= 1'b1;
      gapQ <= tqTick ? 8'h01 : gapQ + {7'h0, gapQ != 8'hff};
      if (arvalid && arready) rdAddrQ <= araddr;
    end
  end

  // --------------------
  // Assertions
  // --------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_RD_RESERVED: assert property (
    rvalid && (rdAddrQ == 8'h00 || rdAddrQ == 8'h08) |-> rdata[31:8] == 24'h0
      && !(rdAddrQ == 8'h00 && rdata[4])) else $error("reserved bits read nonzero");
  AST_IRQ_RAISE: assert property (
    (evVec & enQ) != 8'h00 |-> ##2 irq) else $error("enabled event gave no interrupt");
  AST_IRQ_QUIET: assert property (
    enQ == 8'h00 |=> !irq) else $error("interrupt with all sources disabled");
  AST_TQ_PERIOD: assert property (
    tqTick && tickSeenQ && !chgQ |-> gapQ == period) else $error("quantum period wrong");
  AST_SJW: assert property (
    tmQ[7:6] == $past(tmQ[7:6]) |-> syncJumpQuanta == {1'b0, tmQ[7:6]} + 3'h1)
    else $error("jump width does not follow its field");
  AST_READ_LAT: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("read answer late");
  AST_WRITE_LAT: assert property (
    fire |=> bvalid) else $error("write answer late");
  AST_R_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data not held");
  AST_B_HOLD: assert property (
    bvalid && !bready |=> bvalid) else $error("write answer not held");
  AST_RD_DECERR: assert property (
    rvalid && rdAddrQ[7:4] != 4'h0 |-> rresp == 2'h3 && rdata == 32'h0)
    else $error("unmapped read not refused");

  COV_IRQ: cover property ($rose(irq));
  COV_TICK: cover property (tqTick && tickSeenQ && !chgQ && tmQ[5:0] == 6'h3f);
  COV_DECERR: cover property (rvalid && rresp == 2'h3);
endmodule : can_irq_timing_regs_chk

bind can_irq_timing_regs can_irq_timing_regs_chk i_chk (
  .mclk(mclk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .badMsgEvent(badMsgEvent),
  .wakeEvent(wakeEvent), .fifoFullEvent(fifoFullEvent), .rxOverflowEvent(rxOverflowEvent),
  .rxBufferEvent(rxBufferEvent), .txBufferEvent(txBufferEvent), .tqTick(tqTick),
  .syncJumpQuanta(syncJumpQuanta), .irq(irq));

// *** can_quantum_divider.sv ***
// Time quantum divider: one-cycle enable every 2 x (prescaler + 1) module clocks.
`timescale 1ns/10ps
module can_quantum_divider (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                reset,
  // Prescaler field
  input  wire logic [can_regs_pkg::PRESCALER_W-1:0] quantumPrescaler,
  // Quantum enable
  output logic                                     tqTick
);

  logic [can_regs_pkg::PRESCALER_W:0] count_q;
  wire  [can_regs_pkg::PRESCALER_W:0] terminal = {quantumPrescaler, 1'b1};
  // A lowered prescaler never strands the counter above the new terminal.
  wire                                atEnd    = (count_q >= terminal);

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_q <= '0;
      tqTick  <= 1'b0;
    end else begin
      count_q <= atEnd ? '0 : count_q + 1'b1; // RQ12
      tqTick  <= atEnd; // RQ12
    end
  end

endmodule : can_quantum_divider

// *** can_regs_pkg.sv ***
// Register map, field layout and timing constants of the CAN register block.
package can_regs_pkg;

  // --------------------
  // Bus geometry and answers
  // --------------------
  localparam int          AXI_ADDR_W    = 8;
  localparam int          AXI_DATA_W    = 32;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // --------------------
  // Register byte offsets
  // --------------------
  localparam logic [7:0]  OFF_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0]  OFF_ERROR_COUNTS = 8'h04;
  localparam logic [7:0]  OFF_BIT_TIMING   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_FLAGS    = 8'h0c;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'h0,
    SEL_ENABLE = 3'h1,
    SEL_COUNTS = 3'h3,
    SEL_TIMING = 3'h2,
    SEL_FLAGS  = 3'h6
  } reg_sel_t;

  // --------------------
  // Interrupt flag and enable bit positions
  // --------------------
  localparam int          BIT_BAD_MSG   = 7;
  localparam int          BIT_WAKE      = 6;
  localparam int          BIT_ERR       = 5;
  localparam int          BIT_FIFO_FULL = 3;
  localparam int          BIT_RX_OVF    = 2;
  localparam int          BIT_RX_BUF    = 1;
  localparam int          BIT_TX_BUF    = 0;
  localparam logic [7:0]  IRQ_BITS_MASK = 8'hef;
  localparam logic [7:0]  IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0]  IRQ_FLAGS_RST  = 8'h00;

  // --------------------
  // Bit timing fields
  // --------------------
  localparam int          SJW_LSB        = 6;
  localparam int          PRESCALER_W    = 6;
  localparam logic [7:0]  BIT_TIMING_RST = 8'h00;

  // --------------------
  // Fault confinement limits
  // --------------------
  localparam logic [7:0]  ERR_COUNT_RST  = 8'h00;
  localparam logic [7:0]  WARN_LIMIT     = 8'h60;
  localparam logic [7:0]  PASSIVE_LIMIT  = 8'h80;
  localparam logic [7:0]  REC_REENTRY    = 8'h78;
  localparam logic [7:0]  ERR_STEP_BIG   = 8'h08;
  localparam logic [7:0]  ERR_STEP_ONE   = 8'h01;

endpackage : can_regs_pkg

// *** tb_top.sv ***
// Self-checking bench for the CAN interrupt, error count and bit timing registers.
`timescale 1ns/10ps
module tb_top;
  // --------------------
  // Signals
  // --------------------
  logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready, evStart;
  logic        awready, wready, bvalid, arready, rvalid, tqTick, irq, evBusy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, d, x;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  syncJumpQuanta;
  logic [3:0]  evCode, evDelay, wstrb;
  logic [11:0] evPulse;
  int          n_fail, checks, tec, rec, gap, p, c, b;
  localparam int IRQ_BIT [6] = '{7, 6, 3, 2, 1, 0};

  can_irq_timing_regs i_dut (
    .mclk(mclk), .reset(reset), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .badMsgEvent(evPulse[0]), .wakeEvent(evPulse[1]),
    .fifoFullEvent(evPulse[2]), .rxOverflowEvent(evPulse[3]), .rxBufferEvent(evPulse[4]),
    .txBufferEvent(evPulse[5]), .txErrorEvent(evPulse[6]), .txSuccessEvent(evPulse[7]),
    .rxErrorEvent(evPulse[8]), .rxSevereErrorEvent(evPulse[9]),
    .rxSuccessEvent(evPulse[10]), .busOffRecover(evPulse[11]), .tqTick(tqTick),
    .syncJumpQuanta(syncJumpQuanta), .irq(irq));
  can_event_model i_peer (.mclk(mclk), .reset(reset), .evStart(evStart), .evCode(evCode),
    .evDelay(evDelay), .evPulse(evPulse), .evBusy(evBusy));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // --------------------
  // Tasks
  // --------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic axi_write(input logic [7:0] a, input logic [31:0] dt);
    @(posedge mclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom % 2);
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (!bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    resp = bresp;
    bready <= 1'b0;
    cmp("write resp", 32'((a > 8'h0c || a[1:0] != 2'h0) ? 3 : 0), 32'(resp));
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom % 2);
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (!rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1));
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    cmp("read resp", 32'((a > 8'h0c || a[1:0] != 2'h0) ? 3 : 0), 32'(resp));
  endtask : axi_read

  task automatic fire(input int code);
    evCode <= 4'(code);
    evDelay <= 4'($urandom % 6);
    evStart <= 1'b1;
    @(posedge mclk);
    evStart <= 1'b0;
    do @(posedge mclk); while (evBusy === 1'b1);
    repeat (4) @(posedge mclk);
  endtask : fire

  task automatic tick_gap(output int g);
    for (int k = 0; k < 3; k++) begin
      g = 0;
      do begin
        @(posedge mclk);
        g++;
      end while (tqTick !== 1'b1 && g < 300);
    end
  endtask : tick_gap

  function automatic void exp_counts(input int code);
    case (code)
      6: tec = (tec > 247) ? 255 : tec + 8;
      7: tec = (tec > 0) ? tec - 1 : 0;
      8: rec = (rec < 255) ? rec + 1 : 255;
      9: rec = (rec > 247) ? 255 : rec + 8;
      10: rec = (rec >= 128) ? 120 : ((rec > 0) ? rec - 1 : 0);
      default: begin
        tec = 0;
        rec = 0;
      end
    endcase
  endfunction : exp_counts

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // --------------------
  // Tests
  // --------------------
  initial begin
    #(60000 * 50);
    n_fail++;
    $display("ERROR watchdog expected end of run seen timeout");
    finish_test();
  end

  initial begin
    {reset, awvalid, wvalid, bready, arvalid, rready, evStart} = 7'h40;
    {awaddr, araddr, wdata, evCode, evDelay, wstrb} = 60'h0;
    void'($urandom(32'hf2ed));
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i += 4) begin
      axi_read(8'(i));
      cmp("reset value", 32'h0, rd);
    end
    cmp("jump width", 32'h1, 32'(syncJumpQuanta));
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom;
      wstrb <= (i % 3 == 2) ? 4'he : 4'hf;
      axi_write(8'h00, d);
      axi_read(8'h00);
      if (i % 3 != 2) x = d & 32'h000000ef;
      cmp("irq_enable", x, rd);
    end
    $display("enable register done");
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 63 : ((i == 1) ? 0 : $urandom % 64);
      d = ($urandom & 32'hffffff00) | 32'(i * 64 + p);
      axi_write(8'h08, d);
      axi_read(8'h08);
      cmp("bit_timing_prescale", d & 32'hff, rd);
      cmp("jump width", 32'(i + 1), 32'(syncJumpQuanta));
      tick_gap(gap);
      cmp("quantum period", 32'(2 * (p + 1)), 32'(gap));
    end
    $display("bit timing done");
    for (int i = 0; i < 6; i++) begin
      b = IRQ_BIT[i];
      axi_write(8'h00, ~(32'h1 << b));
      fire(i);
      cmp("masked irq", 32'h0, 32'(irq));
      axi_read(8'h0c);
      cmp("irq_flags", 32'h1 << b, rd);
      axi_write(8'h0c, 32'h1 << b);
      axi_write(8'h00, 32'h1 << b);
      fire(i);
      cmp("enabled irq", 32'h1, 32'(irq));
      axi_write(8'h0c, 32'h1 << b);
      repeat (2) @(posedge mclk);
      cmp("cleared irq", 32'h0, 32'(irq));
    end
    $display("interrupts done");
    tec = 0;
    rec = 0;
    for (int i = 0; i < 24; i++) begin
      c = 6 + $urandom % 5;
      fire(c);
      exp_counts(c);
      axi_read(8'h04);
      cmp("error_counts", 32'(tec * 256 + rec), rd);
    end
    axi_write(8'h04, 32'hffff);
    axi_read(8'h04);
    cmp("error_counts", 32'(tec * 256 + rec), rd);
    fire(11);
    exp_counts(11);
    axi_write(8'h0c, 32'hff);
    axi_write(8'h00, 32'h20);
    repeat (12) fire(6);
    axi_read(8'h0c);
    cmp("irq_flags", 32'h0520, rd);
    cmp("error irq", 32'h1, 32'(irq));
    $display("error counters done");
    axi_write(8'h10, $urandom);
    cmp("unmapped write", 32'h3, 32'(resp));
    axi_read(8'h10);
    cmp("unmapped read", 32'h3, 32'(resp));
    cmp("unmapped data", 32'h0, rd);
    $display("unmapped access done");
    finish_test();
  end
endmodule : tb_top
